/* File: hdl/power_mode_consts.vh */
// Contract
// - supply start-up resets registers, enters sleep
// - wake command bit moves sleep to operating
// - standby command bit returns operating to sleep
// - entering sleep resets the register banks
// - leaving limp home always enters sleep
// - fail-safe input high enters limp home, resets
// - limp home drives channels 4, 5 from inputs
// - fail-safe input high wakes from sleep
// - any reset turns channels off, registers default; sleep and limp entry keep diagnosis flags, limp drives channels 4, 5
// - any reset sets the transmission error flag
// - undervoltage reads return diagnostic frame with flag
// - undervoltage reset released only when supplies good
// - reset command clears banks and diagnosis registers
// - limp home keeps reads, rejects every command
// - bus works with logic supply, battery absent
// - banks kept only with battery, fail-safe low
// - battery undervoltage asserts reset within 1 us
// - input select: off, input 1, input 2, on
`ifndef POWER_MODE_CONSTS_VH
`define POWER_MODE_CONSTS_VH

// register byte offsets
`define ADDR_COMMAND     4'h0
`define ADDR_INPUT_SEL   4'h4
`define ADDR_STATUS      4'h8
`define ADDR_DIAG        4'hc

// command register bits
`define CMD_WAKE_BIT     0
`define CMD_STANDBY_BIT  1
`define CMD_RESET_BIT    2

// status register bits
`define STAT_ON_BIT      0
`define STAT_LIMP_BIT    1
`define STAT_UV_BIT      2
`define STAT_TER_BIT     3
`define STAT_SLEEP_BIT   4
`define STAT_DIAG_LSB    8

// reset values
`define INPUT_SEL_RESET  16'h0000
`define DIAG_RESET       8'h00

// channel input select encodings
`define SEL_OFF          2'h0
`define SEL_IN1          2'h1
`define SEL_IN2          2'h2
`define SEL_ON           2'h3

// undervoltage assert delay, ns, and clock period, ns
`define UV_ASSERT_NS     1000
`define CLK_PERIOD_NS    5
`define UV_ASSERT_CYC    (`UV_ASSERT_NS / `CLK_PERIOD_NS)

`endif

/* File: hdl/power_mode_ctrl.v */
`timescale 1ns/1ps
`include "power_mode_consts.vh"

module power_mode_ctrl #(
    parameter NCH      = 8,
    parameter NDIAG    = 8,
    parameter UV_FILT  = `UV_ASSERT_CYC
) (
    input  wire             clk_i,
    input  wire             rst_i,
    // classic wishbone slave
    input  wire             wb_cyc_i,
    input  wire             wb_stb_i,
    input  wire             wb_we_i,
    input  wire [3:0]       wb_adr_i,
    input  wire [3:0]       wb_sel_i,
    input  wire [31:0]      wb_dat_i,
    output reg  [31:0]      wb_dat_o,
    output reg              wb_ack_o,
    // supplies and pins
    input  wire             vbb_ok_i,
    input  wire             vdd_ok_i,
    input  wire             fail_safe_input_i,
    input  wire             in1_i,
    input  wire             in2_i,
    input  wire [NDIAG-1:0] diag_i,
    // channel drive and state
    output reg  [NCH-1:0]   ch_o,
    output wire             sleep_o,
    output wire             operating_o,
    output wire             limp_home_o,
    output wire             uv_reset_o,
    output wire             bank_reset_o
);

    localparam [2:0] ST_SLEEP = 3'b001;
    localparam [2:0] ST_ON    = 3'b010;
    localparam [2:0] ST_LIMP  = 3'b100;

    reg  [2:0]       state_q;
    reg  [2:0]       state_d;
    reg  [2*NCH-1:0] input_sel_q;
    reg  [NDIAG-1:0] diag_q;
    reg              ter_q;
    reg              limp_q;
    reg  [NCH-1:0]   ch_d;

    wire             uv_rst;
    wire             req;
    wire             wr;
    wire             rd;
    wire             cmd_wr;
    wire             cmd_ok;
    wire             cmd_wake;
    wire             cmd_standby;
    wire             cmd_reset;
    wire             limp_req;
    wire             bank_rst;
    wire             enter_sleep;
    wire             limp_entry;
    wire             any_reset;
    wire             ter_clr;
    wire [31:0]      status_word;

    uv_reset_gen #(
        .FILT_CYC (UV_FILT),
        .CW       (8)
    ) u_uv (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .vbb_ok_i   (vbb_ok_i),
        .vdd_ok_i   (vdd_ok_i),
        .uv_reset_o (uv_rst)
    );

    // bus decode; the slave itself only needs rst_i, not the battery
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr  = req && wb_we_i;
    assign rd  = req && !wb_we_i;

    // commands are dropped in limp home and during undervoltage
    assign cmd_wr      = wr && (wb_adr_i == `ADDR_COMMAND) && wb_sel_i[0];
    assign cmd_ok      = cmd_wr && !limp_q && !uv_rst;
    assign cmd_wake    = cmd_ok && wb_dat_i[`CMD_WAKE_BIT];
    assign cmd_standby = cmd_ok && wb_dat_i[`CMD_STANDBY_BIT];
    assign cmd_reset   = cmd_ok && wb_dat_i[`CMD_RESET_BIT];

    // limp home needs both the battery and the logic supply, as uv_rst covers either
    assign limp_req = fail_safe_input_i && !uv_rst;

    // mode sequencing
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_SLEEP: begin
                if (limp_req) begin
                    state_d = ST_LIMP;
                end else if (cmd_wake) begin
                    state_d = ST_ON;
                end
            end
            ST_ON: begin
                if (uv_rst) begin
                    state_d = ST_SLEEP;
                end else if (limp_req) begin
                    state_d = ST_LIMP;
                end else if (cmd_standby) begin
                    state_d = ST_SLEEP;
                end
            end
            ST_LIMP: begin
                if (!limp_req) begin
                    state_d = ST_SLEEP;
                end
            end
            default: begin
                state_d = ST_SLEEP;
            end
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_SLEEP;
            limp_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            limp_q  <= (state_d == ST_LIMP);
        end
    end

    assign enter_sleep = (state_d == ST_SLEEP) && (state_q != ST_SLEEP);
    assign limp_entry  = (state_d == ST_LIMP) && (state_q != ST_LIMP);

    // banks held reset without battery, in limp home, in sleep,
    // and for a reset command
    assign bank_rst = rst_i || uv_rst || limp_req
                   || (state_d == ST_SLEEP)
                   || cmd_reset;

    // input select bank, one byte lane per four channels
    always @(posedge clk_i) begin
        if (bank_rst) begin
            input_sel_q <= `INPUT_SEL_RESET;
        end else if (wr && (wb_adr_i == `ADDR_INPUT_SEL) && !limp_q) begin
            if (wb_sel_i[0]) begin
                input_sel_q[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                input_sel_q[15:8] <= wb_dat_i[15:8];
            end
        end
    end

    // diagnosis flags latch while diagnostics run; cleared by start-up, undervoltage or the reset command
    always @(posedge clk_i) begin
        if (rst_i || cmd_reset || uv_rst) begin
            diag_q <= `DIAG_RESET;
        end else if (state_q == ST_ON) begin
            diag_q <= diag_q | diag_i;
        end
    end

    // transmission error flag: any reset sets it, write one clears it.
    // set wins over a clear landing in the same cycle
    assign any_reset = uv_rst || limp_entry || cmd_reset
                    || (enter_sleep && !uv_rst);
    assign ter_clr   = wr && (wb_adr_i == `ADDR_STATUS) && wb_sel_i[0]
                    && wb_dat_i[`STAT_TER_BIT] && !uv_rst;

    always @(posedge clk_i) begin
        if (rst_i) begin
            ter_q <= 1'b1;
        end else if (any_reset) begin
            ter_q <= 1'b1;
        end else if (ter_clr) begin
            ter_q <= 1'b0;
        end
    end

    // channel drive
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_ch
            always @* begin
                ch_d[g] = 1'b0;
                if (state_d == ST_LIMP && !bank_rst_only_limp(g)) begin
                    ch_d[g] = 1'b0;
                end else if (state_d == ST_LIMP) begin
                    ch_d[g] = (g == 4) ? in1_i : in2_i;
                end else if (state_d == ST_ON && !cmd_reset) begin
                    case (input_sel_q[2*g+1:2*g])
                        `SEL_OFF: ch_d[g] = 1'b0;
                        `SEL_IN1: ch_d[g] = in1_i;
                        `SEL_IN2: ch_d[g] = in2_i;
                        default:  ch_d[g] = 1'b1;
                    endcase
                end
            end
        end
    endgenerate

    // only the two auto-configuring channels follow pins in limp home
    function bank_rst_only_limp;
        input integer idx;
        begin
            bank_rst_only_limp = (idx == 4) || (idx == 5);
        end
    endfunction

    always @(posedge clk_i) begin
        if (rst_i || uv_rst) begin
            ch_o <= {NCH{1'b0}};
        end else begin
            ch_o <= ch_d;
        end
    end

    // status word; under undervoltage it is the diagnostic frame
    assign status_word = {{(24-NDIAG){1'b0}}, diag_q,
                          3'h0,
                          (state_q == ST_SLEEP),
                          ter_q || uv_rst,
                          uv_rst,
                          limp_q,
                          (state_q == ST_ON)};

    // registered ack: one wait state, released the cycle after
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= req;
            if (rd) begin
                if (uv_rst) begin
                    wb_dat_o <= status_word;
                end else if (wb_adr_i == `ADDR_INPUT_SEL) begin
                    wb_dat_o <= {16'h0000, input_sel_q};
                end else if (wb_adr_i == `ADDR_STATUS) begin
                    wb_dat_o <= status_word;
                end else if (wb_adr_i == `ADDR_DIAG) begin
                    wb_dat_o <= {{(32-NDIAG){1'b0}}, diag_q};
                end else begin
                    wb_dat_o <= 32'h00000000;
                end
            end
        end
    end

    assign sleep_o      = (state_q == ST_SLEEP);
    assign operating_o  = (state_q == ST_ON);
    assign limp_home_o  = limp_q;
    assign uv_reset_o   = uv_rst;
    assign bank_reset_o = bank_rst;

endmodule // power_mode_ctrl

/* File: hdl/uv_reset_gen.v */
`timescale 1ns/1ps
`include "power_mode_consts.vh"

module uv_reset_gen #(
    parameter FILT_CYC = `UV_ASSERT_CYC,
    parameter CW       = 8
) (
    input  wire clk_i,
    input  wire rst_i,
    input  wire vbb_ok_i,
    input  wire vdd_ok_i,
    output wire uv_reset_o
);

    reg [CW-1:0] low_cnt_q;
    reg          uv_q;

    // short battery dips are filtered; longest filter stays inside the
    // documented assert delay, so a real drop always resets in time
    always @(posedge clk_i) begin
        if (rst_i) begin
            low_cnt_q <= {CW{1'b0}};
            uv_q      <= 1'b1;
        end else if (vbb_ok_i && vdd_ok_i) begin
            low_cnt_q <= {CW{1'b0}};
            uv_q      <= 1'b0;
        end else if (!vdd_ok_i) begin
            uv_q      <= 1'b1;
        end else if (low_cnt_q >= FILT_CYC[CW-1:0] - 1'b1) begin
            uv_q      <= 1'b1;
        end else begin
            low_cnt_q <= low_cnt_q + 1'b1;
        end
    end

    assign uv_reset_o = uv_q;

endmodule // uv_reset_gen

/* File: tb/power_mode_sva.sv */
`timescale 1ns/1ps
module power_mode_sva #(
    parameter NCH     = 8,
    parameter UV_FILT = 4
) (
    input wire           clk_i,
    input wire           rst_i,
    input wire           wb_cyc_i,
    input wire           wb_stb_i,
    input wire           wb_ack_o,
    input wire           vbb_ok_i,
    input wire           vdd_ok_i,
    input wire           fail_safe_input_i,
    input wire           in1_i,
    input wire           in2_i,
    input wire [NCH-1:0] ch_o,
    input wire           sleep_o,
    input wire           limp_home_o,
    input wire           uv_reset_o,
    input wire           bank_reset_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    // six low cycles, so the filter of four has settled with margin
    sequence s_bat_low;
        (!vbb_ok_i) [*6];
    endsequence
    a_ack_answer: assert property (s_req |=> wb_ack_o)
        else $error("request not acked");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_reset_off: assert property (disable iff (1'b0)
        rst_i |=> ch_o == 0 && sleep_o && uv_reset_o)
        else $error("reset left channels or mode");
    a_limp_entry: assert property (
        fail_safe_input_i && !uv_reset_o |=> limp_home_o)
        else $error("limp home not entered");
    a_limp_route: assert property (
        limp_home_o && $past(limp_home_o) |->
        ch_o[5:4] == {$past(in2_i), $past(in1_i)} && ch_o[3:0] == 4'h0)
        else $error("limp routing wrong");
    a_limp_exit: assert property (
        $fell(limp_home_o) |-> ##[0:1] sleep_o)
        else $error("no sleep after limp home");
    a_bank_held: assert property (
        sleep_o || limp_home_o |-> $past(bank_reset_o))
        else $error("banks not held in reset");
    a_uv_vdd: assert property (!vdd_ok_i |=> uv_reset_o)
        else $error("logic supply loss not seen");
    a_uv_hold: assert property (
        uv_reset_o && !(vbb_ok_i && vdd_ok_i) |=> uv_reset_o)
        else $error("uv reset released early");
    a_uv_delay: assert property (s_bat_low |-> uv_reset_o)
        else $error("uv reset too late");
endmodule // power_mode_sva
bind power_mode_ctrl power_mode_sva #(.NCH(NCH), .UV_FILT(UV_FILT))
    power_mode_sva_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
    .vbb_ok_i, .vdd_ok_i, .fail_safe_input_i, .in1_i, .in2_i, .ch_o,
    .sleep_o, .limp_home_o, .uv_reset_o, .bank_reset_o);

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
    logic        clk_i = 0, rst_i = 1, vbb = 1, vdd = 1, fs = 0;
    logic        in1 = 0, in2 = 0, go = 0, hwe = 0, i1, i2;
    logic [7:0]  diag = 8'h00;
    logic [3:0]  hadr = 4'h0;
    logic [31:0] hdat = 32'h0, rnd = 32'h00014066;
    logic [63:0] e;
    logic [63:0] expq[$];
    int          err_total = 0, tests_run = 0;
    wire         cyc, bwe, ack, done, slp, opr, limp, uvr, bank;
    wire  [3:0]  badr;
    wire  [31:0] bdat, rdat;
    wire  [7:0]  ch;
    power_mode_ctrl #(.UV_FILT(4)) power_mode_ctrl_inst (.clk_i(clk_i),
        .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(bwe),
        .wb_adr_i(badr), .wb_sel_i(4'hf), .wb_dat_i(bdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .vbb_ok_i(vbb), .vdd_ok_i(vdd),
        .fail_safe_input_i(fs), .in1_i(in1), .in2_i(in2), .diag_i(diag),
        .ch_o(ch), .sleep_o(slp), .operating_o(opr), .limp_home_o(limp),
        .uv_reset_o(uvr), .bank_reset_o(bank));
    wb_host wb_host_inst (.clk_i(clk_i), .go_i(go), .we_i(hwe),
        .adr_i(hadr), .dat_i(hdat), .ack_i(ack), .cyc_o(cyc), .we_o(bwe),
        .adr_o(badr), .dat_o(bdat), .done_o(done));
    initial forever #2.5 clk_i = ~clk_i;
    function logic [31:0] xs(input logic [31:0] v);
        xs = v ^ (v << 13);
        xs = xs ^ (xs >> 17);
        xs = xs ^ (xs << 5);
    endfunction
    task check(input string nm, input logic [31:0] s, x);
        tests_run++;
        if (s !== x) begin
            err_total++;
            $display("[ERR] %s exp %h got %h", nm, x, s);
        end
    endtask
    task end_of_test;
        if (err_total == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task cyc_n(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        go <= 1'b1;
        hwe <= w;
        hadr <= a;
        hdat <= d;
        n = 0;
        @(posedge clk_i);
        while (done !== 1'b1 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        go <= 1'b0;
        check("bus_done", {31'h0, done}, 32'h1);
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task rd(input logic [3:0] a, input logic [31:0] x, m);
        expq.push_back({m, x});
        bus(1'b0, a, 32'h0);
    endtask
    task chk_ch(input logic [7:0] x);
        cyc_n(3);
        check("ch", {24'h0, ch}, {24'h0, x});
    endtask
    // new pin levels land at a clock edge, after the previous wait
    task rnd_in;
        rnd = xs(rnd);
        i1 = rnd[0];
        i2 = rnd[1];
        in1 <= i1;
        in2 <= i2;
    endtask
    always @(posedge clk_i) begin
        if (ack === 1'b1 && bwe === 1'b0 && expq.size() > 0) begin
            e = expq.pop_front();
            check("rdata", rdat & e[63:32], e[31:0]);
        end
    end
    initial begin
        #100000;
        err_total++;
        end_of_test;
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        cyc_n(3);
        rd(4'h8, 32'h18, 32'hffffffff);
        rd(4'h4, 32'h0, 32'hffffffff);
        rd(4'h2, 32'h0, 32'hffffffff);
        wr(4'h8, 32'h8);
        wr(4'h0, 32'h1);
        rd(4'h8, 32'h1, 32'hffffffff);
        check("oper", {31'h0, opr}, 32'h1);
        wr(4'h4, 32'he4e4);
        repeat (4) begin
            rnd_in;
            chk_ch({1'b1, i2, i1, 1'b0, 1'b1, i2, i1, 1'b0});
        end
        diag <= 8'h5a;
        @(posedge clk_i);
        diag <= 8'h00;
        rd(4'hc, 32'h5a, 32'hff);
        wr(4'h0, 32'h4);
        rd(4'hc, 32'h0, 32'hff);
        rd(4'h4, 32'h0, 32'hffff);
        rd(4'h8, 32'h8, 32'h8);
        chk_ch(8'h00);
        wr(4'h0, 32'h2);
        rd(4'h8, 32'h10, 32'h11);
        wr(4'h4, 32'hffff);
        rd(4'h4, 32'h0, 32'hffff);
        fs <= 1'b1;
        repeat (3) begin
            rnd_in;
            chk_ch({2'b00, i2, i1, 4'h0});
        end
        wr(4'h0, 32'h1);
        wr(4'h4, 32'hffff);
        rd(4'h4, 32'h0, 32'hffff);
        rd(4'h8, 32'h2, 32'h3);
        check("limp", {31'h0, limp}, 32'h1);
        fs <= 1'b0;
        cyc_n(3);
        check("sleep", {31'h0, slp}, 32'h1);
        wr(4'h0, 32'h1);
        vbb <= 1'b0;
        cyc_n(10);
        check("uv", {31'h0, uvr}, 32'h1);
        rd(4'h4, 32'hc, 32'hc);
        vbb <= 1'b1;
        vdd <= 1'b0;
        chk_ch(8'h00);
        check("uv", {31'h0, uvr}, 32'h1);
        vdd <= 1'b1;
        cyc_n(3);
        check("uv", {31'h0, uvr}, 32'h0);
        end_of_test;
    end
endmodule // tb

/* File: tb/wb_host.sv */
`timescale 1ns/1ps
module wb_host (
    input  wire        clk_i,
    input  wire        go_i,
    input  wire        we_i,
    input  wire [3:0]  adr_i,
    input  wire [31:0] dat_i,
    input  wire        ack_i,
    output reg         cyc_o = 1'b0,
    output reg         we_o = 1'b0,
    output reg  [3:0]  adr_o = 4'h0,
    output reg  [31:0] dat_o = 32'h0,
    output reg         done_o = 1'b0
);
    // held until ack, then data inverted so stale values never look valid
    always @(posedge clk_i) begin
        done_o <= 1'b0;
        if (cyc_o && ack_i) begin
            cyc_o  <= 1'b0;
            done_o <= 1'b1;
            dat_o  <= ~dat_o;
        end else if (go_i && !cyc_o && !done_o) begin
            cyc_o <= 1'b1;
            we_o  <= we_i;
            adr_o <= adr_i;
            dat_o <= dat_i;
        end
    end
endmodule // wb_host
